// [hdl/emb_ext_bus.v]
`timescale 1ns/1ps
`include "emb_defines.vh"
// Operation
// - address leads multiplexed bus by one cycle
// - address held from t1 through t4
// - high byte strobe low: upper enable and write
// - low byte strobe low: a0 and write
// - narrow variant strobes every byte write
// - write enables share early address timing
// - read strobe low on every read
// - address disable floats bus unless strap low
// - psram only in lower select region
// - lower select precharge gap between psram accesses
// - psram mode cleared at reset
// - refresh by strobe only, no row address
// - psram mode: shared pin carries refresh strobe
// - upper select held high during refresh
// - refresh: lower select high, address unused
module emb_ext_bus #(
  parameter AW = 20,
  parameter WIDE = 1,
  parameter CW = 9
) (
  input wire core_clk, // system clock
  input wire rst_n, // sync reset, active low
  input wire clkEn, // clock enable
  input wire reqValid, // cpu bus request
  input wire reqWrite, // 1 write, 0 read
  input wire [AW-1:0] reqAddr, // byte address
  input wire reqUpperEn, // upper byte lane used
  input wire reqLowerEn, // lower byte lane used
  input wire [15:0] reqWdata, // write data
  input wire reqLower, // access hits lower select
  input wire reqUpper, // access hits upper select
  input wire reqMid3, // access hits midrange select 3
  input wire [4:0] lowerCfg, // lower_mem_select_cfg bits
  input wire upperAddrDisable, // upper_mem_select_cfg disable bit
  input wire [CW-1:0] rfshReload, // refresh_prescaler_reg reload
  input wire addressEnableStrap_n, // strap sampled on first enabled edge after reset
  input wire [15:0] adIn, // multiplexed bus input
  output reg reqReady, // cycle done pulse
  output reg [15:0] rdData, // read data
  output reg [AW-1:0] nonmuxAddressBus, // early address
  output reg [15:0] adOut, // multiplexed bus out
  output reg adOe, // multiplexed bus drive
  output reg writeStrobe_n, // write strobe
  output reg readStrobe_n, // read strobe / output enable
  output reg upperHalfEnable_n, // upper half enable
  output reg highByteWriteEn_n, // high byte write enable
  output reg lowByteWriteEn_n, // low byte or byte write enable
  output reg lowerMemSelect_n, // lower select
  output reg upperMemSelect_n, // upper select
  output reg midSel3OrRefresh_n, // shared refresh / select 3 pin
  output reg inRefresh // refresh cycle in progress
);
  localparam IDLE = `EMB_PH_IDLE;
  localparam T1 = `EMB_PH_T1;
  localparam T2 = `EMB_PH_T2;
  localparam T3 = `EMB_PH_T3;
  localparam TW = `EMB_PH_TW;
  localparam T4 = `EMB_PH_T4;
  localparam [31:0] GAP_FULL = `EMB_PRECHARGE_CYC;
  localparam [1:0] GAP_CYC = GAP_FULL[1:0];

  reg [5:0] stQ;
  reg strapQ;
  reg strapCaught;
  reg [1:0] waitQ;
  reg [1:0] gapQ;
  reg wrQ, lowQ, upQ, m3Q, rfQ, daQ, ueQ, leQ;
  reg [AW-1:0] addrQ;
  reg [15:0] wdQ;
  wire psramOn = lowerCfg[`EMB_CFG_PSRAM_EN];
  wire rfshPend;

  emb_refresh_timer #(.CW(CW)) uTimer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .enable(psramOn),
    .reload(rfshReload),
    .taken(stQ == IDLE && rfshPend && gapQ == 2'h0),
    .pending(rfshPend)
  );

  // decide whether the address phase is floated
  function addrFloat;
    input lo;
    input up;
    input [4:0] cfg;
    input upDis;
    input strap;
    begin
      addrFloat = strap && ((lo && cfg[`EMB_CFG_ADDR_DIS]) || (up && upDis));
    end
  endfunction

  always @(posedge core_clk) begin
    if (!rst_n) begin
      stQ <= IDLE;
      strapCaught <= 1'b0;
      strapQ <= 1'b0;
      waitQ <= 2'h0;
      gapQ <= 2'h0;
      {wrQ, lowQ, upQ, m3Q, rfQ, daQ, ueQ, leQ} <= 8'h00;
      addrQ <= {AW{1'b0}};
      wdQ <= 16'h0000;
      reqReady <= 1'b0;
      rdData <= 16'h0000;
      nonmuxAddressBus <= {AW{1'b0}};
      adOut <= 16'h0000;
      adOe <= 1'b0;
      writeStrobe_n <= 1'b1;
      readStrobe_n <= 1'b1;
      upperHalfEnable_n <= 1'b1;
      highByteWriteEn_n <= 1'b1;
      lowByteWriteEn_n <= 1'b1;
      lowerMemSelect_n <= 1'b1;
      upperMemSelect_n <= 1'b1;
      midSel3OrRefresh_n <= 1'b1;
      inRefresh <= 1'b0;
    end else if (clkEn) begin
      // strap caught on first enabled edge after release
      if (!strapCaught) begin
        strapCaught <= 1'b1;
        strapQ <= addressEnableStrap_n;
      end
      reqReady <= 1'b0;
      if (gapQ != 2'h0)
        gapQ <= gapQ - 2'h1;
      case (stQ)
        IDLE: begin
          adOe <= 1'b0;
          if (rfshPend && gapQ == 2'h0) begin
            // refresh: strobe only, no address, lower select held high
            rfQ <= 1'b1;
            inRefresh <= 1'b1;
            midSel3OrRefresh_n <= 1'b0;
            lowerMemSelect_n <= 1'b1;
            // upper select is also held high in refresh
            upperMemSelect_n <= 1'b1;
            stQ <= T1;
          end else if (reqValid && !(reqLower && psramOn && gapQ != 2'h0)) begin
            rfQ <= 1'b0;
            wrQ <= reqWrite;
            addrQ <= reqAddr;
            wdQ <= reqWdata;
            lowQ <= reqLower;
            upQ <= reqUpper;
            m3Q <= reqMid3;
            ueQ <= reqUpperEn;
            leQ <= reqLowerEn;
            daQ <= addrFloat(reqLower, reqUpper, lowerCfg,
                             upperAddrDisable, strapQ);
            // address put out now, one cycle before the mux bus
            nonmuxAddressBus <= reqAddr;
            stQ <= T1;
          end
        end
        T1: begin
          if (!rfQ) begin
            adOut <= addrQ[15:0];
            adOe <= !daQ;
            lowerMemSelect_n <= !lowQ;
            upperMemSelect_n <= !upQ;
            midSel3OrRefresh_n <= !(m3Q && !psramOn);
            upperHalfEnable_n <= WIDE ? !ueQ : 1'b1;
          end
          waitQ <= (lowQ && psramOn) ? 2'h1 :
                   lowerCfg[`EMB_CFG_WAIT_HI:`EMB_CFG_WAIT_LO];
          stQ <= T2;
        end
        T2: begin
          adOe <= wrQ && !rfQ;
          adOut <= wdQ;
          if (!rfQ) begin
            writeStrobe_n <= !wrQ;
            readStrobe_n <= wrQ;
            // write enables follow strobe with early address timing
            if (WIDE) begin
              highByteWriteEn_n <= !(wrQ && ueQ);
              lowByteWriteEn_n <= !(wrQ && leQ && !addrQ[0]);
            end else begin
              lowByteWriteEn_n <= !wrQ;
            end
          end
          stQ <= T3;
        end
        T3, TW: begin
          if (waitQ != 2'h0) begin
            waitQ <= waitQ - 2'h1;
            stQ <= TW;
          end else begin
            if (!wrQ && !rfQ)
              rdData <= adIn;
            stQ <= T4;
          end
        end
        T4: begin
          writeStrobe_n <= 1'b1;
          readStrobe_n <= 1'b1;
          highByteWriteEn_n <= 1'b1;
          lowByteWriteEn_n <= 1'b1;
          upperHalfEnable_n <= 1'b1;
          lowerMemSelect_n <= 1'b1;
          upperMemSelect_n <= 1'b1;
          midSel3OrRefresh_n <= 1'b1;
          adOe <= 1'b0;
          inRefresh <= 1'b0;
          reqReady <= !rfQ;
          // psram gets a deselect gap before the next lower access
          if (lowQ && psramOn && !rfQ)
            gapQ <= GAP_CYC;
          stQ <= IDLE;
        end
        default: stQ <= IDLE;
      endcase
      // nonmux address stands unchanged t1..t4: only loaded in idle
    end
  end
endmodule

// [common/emb_defines.vh]
`ifndef EMB_DEFINES_VH
`define EMB_DEFINES_VH
// bus cycle phase codes (one-hot)
`define EMB_PH_IDLE 6'h01
`define EMB_PH_T1 6'h02
`define EMB_PH_T2 6'h04
`define EMB_PH_T3 6'h08
`define EMB_PH_TW 6'h10
`define EMB_PH_T4 6'h20
// lower select config field positions
`define EMB_CFG_WAIT_LO 0
`define EMB_CFG_WAIT_HI 1
`define EMB_CFG_IGN_RDY 2
`define EMB_CFG_PSRAM_EN 3
`define EMB_CFG_ADDR_DIS 4
`define EMB_CFG_RST 5'h00
// refresh reload floor software should respect
`define EMB_PSRAM_REFRESH_STROBE_N_MIN 9'h012
`define EMB_PSRAM_REFRESH_STROBE_N_RST 9'h1ff
// precharge gap of the lower select between psram accesses
`define EMB_PRECHARGE_NS 50
`define EMB_CLK_NS 50
`define EMB_PRECHARGE_CYC ((`EMB_PRECHARGE_NS + `EMB_CLK_NS - 1) / `EMB_CLK_NS)
`endif

// [hdl/emb_refresh_timer.v]
`timescale 1ns/1ps
`include "emb_defines.vh"
module emb_refresh_timer #(
  parameter CW = 9
) (
  input wire core_clk, // system clock
  input wire rst_n, // sync reset
  input wire clkEn, // clock enable
  input wire enable, // psram mode on
  input wire [CW-1:0] reload, // refresh interval
  input wire taken, // refresh cycle started
  output reg pending // refresh request
);
  reg [CW-1:0] cntQ;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      cntQ <= {CW{1'b1}};
      pending <= 1'b0;
    end else if (clkEn) begin
      if (!enable) begin
        cntQ <= reload;
        pending <= 1'b0;
      end else begin
        if (cntQ == {CW{1'b0}}) begin
          cntQ <= reload;
          pending <= 1'b1;
        end else begin
          cntQ <= cntQ - {{(CW-1){1'b0}}, 1'b1};
        end
        // request set wins over its acknowledge
        if (taken && !(cntQ == {CW{1'b0}}))
          pending <= 1'b0;
      end
    end
  end
endmodule

// [tb/emb_ext_bus_checker.sv]
`timescale 1ns/1ps
module emb_ext_bus_checker #(
  parameter AW = 20,
  parameter WIDE = 1
) (
  input wire core_clk, // clock
  input wire rst_n, // reset
  input wire [4:0] lowerCfg, // lower cfg
  input wire [AW-1:0] nonmuxAddressBus, // address
  input wire [15:0] adOut, // mux bus
  input wire adOe, // mux drive
  input wire writeStrobe_n, // write
  input wire readStrobe_n, // read
  input wire upperHalfEnable_n, // upper half
  input wire highByteWriteEn_n, // high we
  input wire lowByteWriteEn_n, // low we
  input wire lowerMemSelect_n, // lower sel
  input wire midSel3OrRefresh_n, // shared pin
  input wire inRefresh // refresh
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_hb; !highByteWriteEn_n |-> !upperHalfEnable_n && !writeStrobe_n;
  endproperty
  a_hb: assert property (p_hb) else $error("high we");
  property p_lb; WIDE == 1 && !lowByteWriteEn_n |->
    !nonmuxAddressBus[0] && !writeStrobe_n; endproperty
  a_lb: assert property (p_lb) else $error("low we");
  property p_ah; !(writeStrobe_n && readStrobe_n) |->
    $stable(nonmuxAddressBus); endproperty
  a_ah: assert property (p_ah) else $error("addr hold");
  // address phase only: strobes still high when the bus first drives
  property p_ld; $rose(adOe) && writeStrobe_n && readStrobe_n |->
    adOut == nonmuxAddressBus[15:0] && $stable(nonmuxAddressBus); endproperty
  a_ld: assert property (p_ld) else $error("addr lead");
  property p_rl; inRefresh |-> lowerMemSelect_n; endproperty
  a_rl: assert property (p_rl) else $error("lower sel");
  property p_rs; $fell(midSel3OrRefresh_n) && lowerCfg[3] |-> inRefresh;
  endproperty
  a_rs: assert property (p_rs) else $error("shared pin");
  // the deselect must outlast the idle edge that any back-to-back gets
  property p_pc; lowerCfg[3] && $rose(lowerMemSelect_n) |=>
    lowerMemSelect_n [*2]; endproperty
  a_pc: assert property (p_pc) else $error("precharge");
  property p_po; $rose(inRefresh) |-> lowerCfg[3]; endproperty
  a_po: assert property (p_po) else $error("refresh off");
endmodule
bind emb_ext_bus emb_ext_bus_checker #(.AW(AW), .WIDE(WIDE)) u_chk (
  .core_clk, .rst_n, .lowerCfg, .nonmuxAddressBus, .adOut, .adOe,
  .writeStrobe_n, .readStrobe_n, .upperHalfEnable_n, .highByteWriteEn_n,
  .lowByteWriteEn_n, .lowerMemSelect_n, .midSel3OrRefresh_n, .inRefresh);

// [tb/emb_mem_model.sv]
`timescale 1ns/1ps
module emb_mem_model (
  input wire core_clk, // clock
  input wire [19:0] addr, // early address
  input wire [15:0] wdata, // bus data
  input wire sel_n, // select
  input wire oe_n, // output enable
  input wire hiWe_n, // high byte we
  input wire loWe_n, // low byte we
  output wire [15:0] rdOut // read data
);
  reg [15:0] mem [0:15];
  reg [15:0] lastQ = 16'h0000;
  wire [15:0] word = mem[addr[4:1]];
  // released bus shows the inverse of the last value, never a held copy
  assign rdOut = (!oe_n && !sel_n) ? word : ~lastQ;
  always @(posedge core_clk) begin
    if (!oe_n && !sel_n) lastQ <= word;
    if (!hiWe_n) mem[addr[4:1]][15:8] <= wdata[15:8];
    if (!loWe_n) mem[addr[4:1]][7:0] <= wdata[7:0];
  end
endmodule

// [tb/emb_ext_bus_tb.sv]
`timescale 1ns/1ps
module emb_ext_bus_tb;
  reg core_clk = 1'h0, rst_n = 1'h0, reqValid = 1'h0, reqWrite = 1'h0;
  reg reqUpperEn = 1'h0, reqLowerEn = 1'h0, reqLower = 1'h0;
  reg reqUpper = 1'h0, reqMid3 = 1'h0, chain = 1'h0;
  reg strapN = 1'h1, upperDis = 1'h0;
  reg [5:0] saw;
  reg [19:0] reqAddr = 20'h00000;
  reg [15:0] reqWdata = 16'h0000, q, n;
  reg [4:0] lowerCfg = 5'h00;
  reg [8:0] rfshReload = 9'h012;
  wire [15:0] adIn, rdData, adOut;
  wire [19:0] nonmuxAddressBus;
  wire reqReady, adOe, writeStrobe_n, readStrobe_n, upperHalfEnable_n;
  wire highByteWriteEn_n, lowByteWriteEn_n, lowerMemSelect_n;
  wire midSel3OrRefresh_n, inRefresh;
  wire upperMemSelect_n, wb8, hbw8;
  integer failures = 0, n_compared = 0, cyc = 0;
  emb_ext_bus uut (.core_clk, .rst_n, .clkEn(1'h1), .reqValid, .reqWrite,
    .reqAddr, .reqUpperEn, .reqLowerEn, .reqWdata, .reqLower, .reqUpper,
    .reqMid3, .lowerCfg, .upperAddrDisable(upperDis), .rfshReload,
    .addressEnableStrap_n(strapN), .adIn, .reqReady, .rdData,
    .nonmuxAddressBus, .adOut, .adOe, .writeStrobe_n, .readStrobe_n,
    .upperHalfEnable_n, .highByteWriteEn_n, .lowByteWriteEn_n,
    .lowerMemSelect_n, .upperMemSelect_n, .midSel3OrRefresh_n,
    .inRefresh);
  // narrow variant in lockstep: only its write enables are watched
  emb_ext_bus #(.WIDE(0)) uutNarrow (.core_clk, .rst_n, .clkEn(1'h1),
    .reqValid, .reqWrite, .reqAddr, .reqUpperEn, .reqLowerEn, .reqWdata,
    .reqLower, .reqUpper, .reqMid3, .lowerCfg, .upperAddrDisable(upperDis),
    .rfshReload, .addressEnableStrap_n(strapN), .adIn, .reqReady(),
    .rdData(), .nonmuxAddressBus(), .adOut(), .adOe(), .writeStrobe_n(),
    .readStrobe_n(), .upperHalfEnable_n(), .highByteWriteEn_n(hbw8),
    .lowByteWriteEn_n(wb8), .lowerMemSelect_n(), .upperMemSelect_n(),
    .midSel3OrRefresh_n(), .inRefresh());
  emb_mem_model mem (.core_clk, .addr(nonmuxAddressBus), .wdata(adOut),
    .sel_n(lowerMemSelect_n), .oe_n(readStrobe_n),
    .hiWe_n(highByteWriteEn_n), .loWe_n(lowByteWriteEn_n), .rdOut(adIn));
  always #25 core_clk = ~core_clk;
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // counts edges from the start, so n is latency plus one; with chain set
  // the request stays up so the next call follows back to back
  task xfer(input w, input [19:0] a, input [1:0] ln, input [1:0] rg,
    input [15:0] d);
    begin
      if (reqValid !== 1'h1)
        @(negedge core_clk);
      reqValid = 1'h1;
      reqWrite = w;
      reqAddr = a;
      {reqUpperEn, reqLowerEn} = ln;
      reqLower = (rg == 2'h0);
      reqUpper = (rg == 2'h1);
      reqMid3 = (rg == 2'h2);
      reqWdata = d;
      saw = 6'h00;
      n = 16'h0000;
      // a chained call starts while the previous ready pulse still stands
      while ((n == 16'h0000 || reqReady !== 1'h1) && n < 16'h0032) begin
        @(posedge core_clk);
        #1;
        n = n + 16'h0001;
        saw = saw | {!hbw8, !wb8, !lowByteWriteEn_n,
          !midSel3OrRefresh_n && !inRefresh, !upperMemSelect_n, adOe};
      end
      q = rdData;
      @(negedge core_clk);
      if (!chain)
        reqValid = 1'h0;
    end
  endtask
  task t_rw;
    begin
      xfer(1'h1, 20'h00010, 2'h3, 2'h0, 16'h1234);
      chk(n, 16'h0005);
      xfer(1'h1, 20'h00010, 2'h1, 2'h0, 16'h00cd);
      xfer(1'h1, 20'h00011, 2'h2, 2'h0, 16'hab00);
      chk(saw[3], 16'h0000);
      chk(saw[4], 16'h0001);
      chk(saw[5], 16'h0000);
      lowerCfg = 5'h02;
      xfer(1'h0, 20'h00010, 2'h3, 2'h0, 16'h0000);
      chk(q, 16'habcd);
      chk(n, 16'h0007);
      chk(saw[0], 16'h0001);
      chk(saw[4], 16'h0000);
    end
  endtask
  task t_dis;
    begin
      lowerCfg = 5'h10;
      xfer(1'h0, 20'h00010, 2'h3, 2'h0, 16'h0000);
      chk(saw[0], 16'h0000);
      chk(q, 16'habcd);
      xfer(1'h0, 20'h80000, 2'h3, 2'h1, 16'h0000);
      chk(saw[0], 16'h0001);
      chk(saw[1], 16'h0001);
      upperDis = 1'h1;
      xfer(1'h0, 20'h80000, 2'h3, 2'h1, 16'h0000);
      chk(saw[0], 16'h0000);
      xfer(1'h0, 20'h40000, 2'h3, 2'h2, 16'h0000);
      chk(saw[2], 16'h0001);
      repeat (40) @(negedge core_clk) chk(inRefresh, 16'h0000);
    end
  endtask
  // strap low through a second reset: disable bits are then ignored
  task t_strap;
    begin
      @(negedge core_clk);
      rst_n = 1'h0;
      strapN = 1'h0;
      repeat (2) @(negedge core_clk);
      rst_n = 1'h1;
      @(negedge core_clk);
      strapN = 1'h1;
      xfer(1'h0, 20'h00010, 2'h3, 2'h0, 16'h0000);
      chk(saw[0], 16'h0001);
      chk(q, 16'habcd);
    end
  endtask
  task t_psram;
    begin
      lowerCfg = 5'h0d;
      n = 16'h0000;
      while (inRefresh !== 1'h1 && n < 16'h0064) begin
        @(negedge core_clk);
        n = n + 16'h0001;
      end
      chk(midSel3OrRefresh_n, 16'h0000);
      // no refresh address is driven: lower select stays high
      chk(lowerMemSelect_n, 16'h0001);
      xfer(1'h0, 20'h40000, 2'h3, 2'h2, 16'h0000);
      chk(saw[2], 16'h0000);
      chain = 1'h1;
      xfer(1'h1, 20'h00010, 2'h3, 2'h0, 16'h5a5a);
      chain = 1'h0;
      xfer(1'h0, 20'h00010, 2'h3, 2'h0, 16'h0000);
      chk(q, 16'h5a5a);
    end
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      failures = failures + 1;
      final_report;
    end
  end
  initial begin
    repeat (10) @(negedge core_clk);
    rst_n = 1'h1;
    repeat (2) @(negedge core_clk);
    t_rw;
    t_dis;
    t_strap;
    t_psram;
    final_report;
  end
endmodule
